/* arb_pick.sv */
// Combinational highest-priority picker over a set of candidates
`timescale 1ns/1ps
module arb_pick
  import coproc_irq_pkg::*;
#(
  parameter int N = 13,
  parameter int W = 8,
  parameter int IW = 4
) (
  // Candidates
  input wire logic [N-1:0] i_valid,
  input wire logic [N-1:0][W-1:0] i_prio,
  // Winner
  output logic o_found,
  output logic [IW-1:0] o_idx,
  output logic [W-1:0] o_prio
);

  // Refuse sizes the index cannot cover
  if (N < 1 || N > (1 << IW) || W < 1) begin : g_bad_size
    $error("arb_pick: unsupported size");
  end

  // Highest number wins, ties go to the lowest index
  always_comb begin
    o_found = 1'b0;
    o_idx = '0;
    o_prio = '0;
    for (int i = 0; i < N; i++) begin
      if (i_valid[i] && (!o_found || i_prio[i] > o_prio)) begin
        o_found = 1'b1;
        o_idx = IW'(i);
        o_prio = i_prio[i];
      end
    end
  end

endmodule

/* channel_proc_interrupt_unit.sv */
// Co-processor arbitration unit and internal request node queues
//
// Operation
// - Co-processor requests start a round; winner priority goes to kernel
// - While the kernel is busy the winner waits, not accepted
// - Kernel acceptance acknowledges the winner, clearing its pending flag
// - Round length is one to four arbitration cycles
// - Each arbitration cycle lasts one or two bus clocks
// - Node registers are kernel-written only; bus writes raise nothing
// - Nodes 0 and 1 always target the CPU
// - Nodes 2 and 3 always target the co-processor
// - Nodes 4 to 8 take a configured target; 10 or 11 disables
// - Nodes 9 to 11 are extended and target the co-processor
// - Every node's enable bit reads as one
// - New requests go to the next free entry of their queue
// - A queue with no free entry reports full
// - Exit posts only with irq flag and true condition, queue by target
// - Exit request stores its priority in the chosen node
// - Suspension always posts into an extended node
// - Suspension sets pending and resume, stores run priority and channel
// - Accepting a resume request sends no external acknowledge
// - o_suspend_ok needs two free self nodes, one extended; a suspension post is taken with one free extended node
// - Error posts to the CPU queue with the global error priority
// - Error records cause and executing channel
// - With no free entry the post stalls until one frees
// - Full self queue forces a round without external requests
// - System bus errors raise no CPU request
`timescale 1ns/1ps
module channel_proc_interrupt_unit
  import coproc_irq_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Configuration
  input wire arb_ctrl_s i_arb_ctrl,
  input wire logic [PROG_HI-PROG_LO:0][1:0] i_prog_tos,
  input wire logic [PRIO_W-1:0] i_error_req_priority,
  // Request posting from the kernel
  input wire logic i_post_valid,
  input wire post_s i_post,
  output logic o_post_ready,
  output logic o_suspend_ok,
  // External requests on the co-processor arbitration bus
  input wire logic i_ext_req,
  input wire logic [PRIO_W-1:0] i_ext_prio,
  output logic o_ext_ack,
  // Kernel handshake
  input wire logic i_kernel_busy,
  input wire logic i_kernel_accept,
  output logic o_kernel_req,
  output logic [PRIO_W-1:0] o_pending_win_priority,
  output logic o_win_resume,
  output logic [CHAN_W-1:0] o_win_chan,
  // CPU interrupt bus side
  input wire logic i_cpu_ack,
  output logic o_cpu_req,
  output logic [IDX_W-1:0] o_cpu_node,
  output logic [PRIO_W-1:0] o_cpu_prio,
  // Status
  output logic o_cpu_queue_full,
  output logic o_self_queue_full,
  output err_status_s o_err_status,
  output node_s [NODES-1:0] o_node_regs
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Target of a node: fixed except the programmable group
  function automatic logic [1:0] node_tos(input int idx,
      input logic [PROG_HI-PROG_LO:0][1:0] prog);
    if (idx <= CPU_HI) begin
      node_tos = TOS_CPU;
    end else if (idx >= PROG_LO && idx <= PROG_HI) begin
      node_tos = prog[idx-PROG_LO];
    end else begin
      node_tos = TOS_COP;
    end
  endfunction

  // Lowest free node in a mask, found flag on top
  function automatic logic [IDX_W:0] first_free(
      input logic [NODES-1:0] m);
    first_free = '0;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_free = {1'b1, IDX_W'(i)};
      end
    end
  endfunction

  // Last tick of a round, counted down to zero
  function automatic logic [2:0] round_len(input arb_ctrl_s c);
    logic [3:0] n;
    n = {2'h0, c.arb_cycles_per_round} + 4'h1;
    if (!c.arb_cycle_length_sel) begin
      n = n << 1;
    end
    round_len = 3'(n - 4'h1);
  endfunction

  // ----------------------------------------------------------------
  // State and masks
  // ----------------------------------------------------------------
  state_s st;
  state_s next_st;
  logic [NODES-1:0] pend;
  logic [NODES-1:0] cpu_mask;
  logic [NODES-1:0] self_mask;
  logic [NODES-1:0] ext_mask;
  logic [NODES-1:0] free_cpu;
  logic [NODES-1:0] free_self;
  logic [NODES-1:0] free_ext;
  logic [NODES-1:0] cpu_ack_vec;
  logic [NODES:0] part_valid;
  logic [NODES:0][PRIO_W-1:0] part_prio;
  logic [NODES-1:0][PRIO_W-1:0] slot_prio;
  logic win_found;
  logic [IDX_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_prio;
  logic cpu_found;
  logic [IDX_W-1:0] cpu_idx;
  logic [PRIO_W-1:0] cpu_prio;
  logic [3:0] self_free_cnt;
  logic post_req;
  logic post_resume;
  logic post_ready;
  logic [IDX_W:0] alloc;
  logic [PRIO_W-1:0] post_prio;
  logic err_capture;

  // Group membership, free entries and arbitration candidates
  always_comb begin
    self_free_cnt = '0;
    for (int i = 0; i < NODES; i++) begin
      pend[i] = st.slot[i].pending;
      slot_prio[i] = st.slot[i].prio;
      cpu_mask[i] = node_tos(i, i_prog_tos) == TOS_CPU;
      self_mask[i] = node_tos(i, i_prog_tos) == TOS_COP;
      ext_mask[i] = i >= EXT_LO;
    end
    free_cpu = cpu_mask & ~pend;
    free_self = self_mask & ~pend;
    free_ext = ext_mask & free_self;
    for (int i = 0; i < NODES; i++) begin
      self_free_cnt = self_free_cnt + {3'h0, free_self[i]};
    end
    cpu_ack_vec = (i_cpu_ack && st.cpu_req)
      ? ({{(NODES-1){1'b0}}, 1'b1} << st.cpu_node) : '0;
    part_valid = {i_ext_req && (|free_self), pend & self_mask};
    part_prio = {i_ext_prio, slot_prio};
  end

  // Co-processor round winner, external request at the top index
  arb_pick #(.N(NODES + 1), .W(PRIO_W), .IW(IDX_W)) u_self_pick (
    .i_valid(part_valid),
    .i_prio(part_prio),
    .o_found(win_found),
    .o_idx(win_idx),
    .o_prio(win_prio)
  );

  // Best CPU-bound node, excluding the one acknowledged now
  arb_pick #(.N(NODES), .W(PRIO_W), .IW(IDX_W)) u_cpu_pick (
    .i_valid(pend & cpu_mask & ~cpu_ack_vec),
    .i_prio(slot_prio),
    .o_found(cpu_found),
    .o_idx(cpu_idx),
    .o_prio(cpu_prio)
  );

  // ----------------------------------------------------------------
  // Posting: allocation of queue entries
  // ----------------------------------------------------------------
  always_comb begin
    post_req = 1'b0;
    post_resume = 1'b0;
    alloc = '0;
    post_prio = i_post.req_priority_num;
    case (i_post.kind)
      POST_EXIT: begin
        if (i_post.exit_irq_flag && i_post.exit_condition) begin
          if (i_post.service_target_sel == TOS_CPU) begin
            post_req = 1'b1;
            alloc = first_free(free_cpu);
          end else if (i_post.service_target_sel == TOS_COP) begin
            post_req = 1'b1;
            alloc = first_free(free_self);
          end
        end
      end
      POST_SUSP: begin
        post_req = 1'b1;
        post_resume = 1'b1;
        alloc = first_free(free_ext);
      end
      POST_ERR: begin
        post_req = !i_post.bus_err;
        post_prio = i_error_req_priority;
        alloc = first_free(free_cpu);
      end
      default: begin
        post_req = 1'b0;
      end
    endcase
    post_ready = i_ce && (!post_req || alloc[IDX_W]);
  end

  // ----------------------------------------------------------------
  // Next state: acknowledges, arbitration, posting
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ext_ack = 1'b0;
    // CPU bus acknowledge frees the offered node
    if (cpu_ack_vec != '0) begin
      next_st.slot[st.cpu_node].pending = 1'b0;
      next_st.slot[st.cpu_node].resume = 1'b0;
    end
    next_st.cpu_req = cpu_found;
    next_st.cpu_node = cpu_idx;
    next_st.cpu_prio = cpu_prio;
    // Arbitration rounds and kernel handshake
    case (st.fsm)
      ST_IDLE: begin
        if (|part_valid) begin
          next_st.fsm = ST_ARB;
          next_st.tick = round_len(i_arb_ctrl);
        end
      end
      ST_ARB: begin
        if (st.tick != 3'h0) begin
          next_st.tick = st.tick - 3'h1;
        end else if (win_found) begin
          next_st.fsm = ST_OFFER;
          next_st.win_prio = win_prio;
          next_st.win_src = win_idx;
          next_st.win_resume = 1'b0;
          next_st.win_chan = '0;
          if (win_idx != EXT_SRC) begin
            next_st.win_resume = st.slot[win_idx].resume;
            next_st.win_chan = st.slot[win_idx].chan;
          end
        end else begin
          next_st.fsm = ST_IDLE;
        end
      end
      ST_OFFER: begin
        if (i_kernel_accept && !i_kernel_busy) begin
          next_st.fsm = ST_IDLE;
          if (st.win_src == EXT_SRC) begin
            next_st.ext_ack = 1'b1;
          end else begin
            next_st.slot[st.win_src].pending = 1'b0;
            next_st.slot[st.win_src].resume = 1'b0;
          end
        end
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase
    // New request into the chosen free entry
    if (i_post_valid && post_ready && post_req) begin
      next_st.slot[alloc[IDX_W-1:0]].pending = 1'b1;
      next_st.slot[alloc[IDX_W-1:0]].resume = post_resume;
      next_st.slot[alloc[IDX_W-1:0]].prio = post_prio;
      next_st.slot[alloc[IDX_W-1:0]].chan = i_post.chan;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= STATE_RST;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Error status record
  // ----------------------------------------------------------------
  assign err_capture = i_post_valid && post_ready
    && i_post.kind == POST_ERR;

  err_status_rec u_err_rec (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_capture(err_capture),
    .i_cause(i_post.cause),
    .i_chan(i_post.chan),
    .o_status(o_err_status)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_post_ready = post_ready;
  assign o_suspend_ok = self_free_cnt >= 4'h2 && (|free_ext);
  assign o_cpu_queue_full = ~|free_cpu;
  assign o_self_queue_full = ~|free_self;
  assign o_kernel_req = st.fsm == ST_OFFER;
  assign o_pending_win_priority = st.win_prio;
  assign o_win_resume = st.win_resume;
  assign o_win_chan = st.win_chan;
  assign o_ext_ack = st.ext_ack;
  assign o_cpu_req = st.cpu_req;
  assign o_cpu_node = st.cpu_node;
  assign o_cpu_prio = st.cpu_prio;

  // Read-only view of the nodes; no write path exists
  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      o_node_regs[i].req_enable_bit = REQ_ENABLE;
      o_node_regs[i].service_target_sel = node_tos(i, i_prog_tos);
      o_node_regs[i].req_pending_flag = st.slot[i].pending;
      o_node_regs[i].resume_request_flag = st.slot[i].resume;
      o_node_regs[i].req_priority_num = st.slot[i].prio;
      o_node_regs[i].saved_channel_num = st.slot[i].chan;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_offer_busy;
    i_ce && st.fsm == ST_OFFER && i_kernel_busy;
  endsequence

  sequence s_accept_int;
    i_ce && st.fsm == ST_OFFER && i_kernel_accept && !i_kernel_busy
      && st.win_src != EXT_SRC;
  endsequence

  sequence s_round_start;
    i_ce && st.fsm == ST_IDLE && next_st.fsm == ST_ARB;
  endsequence

  sequence s_round_end;
    i_ce && st.fsm == ST_ARB && st.tick == 3'h0;
  endsequence

  win_matches_node_a: assert property (st.fsm == ST_OFFER
    && st.win_src != EXT_SRC |-> pend[st.win_src]
    && st.slot[st.win_src].prio == st.win_prio)
    else $error("Offered winner does not match its node");

  busy_holds_offer_a: assert property (s_offer_busy
    |=> st.fsm == ST_OFFER && !st.ext_ack)
    else $error("Winner taken while kernel busy");

  accept_clears_a: assert property (s_accept_int
    |=> !pend[$past(st.win_src)] && !st.ext_ack)
    else $error("Accepted node not cleared or ack sent");

  round_length_a: assert property (s_round_start
    |=> st.tick == round_len($past(i_arb_ctrl)))
    else $error("Round length wrong");

  fixed_targets_a: assert property (
    o_node_regs[0].service_target_sel == TOS_CPU
    && o_node_regs[3].service_target_sel == TOS_COP
    && o_node_regs[EXT_HI].service_target_sel == TOS_COP
    && (&{o_node_regs[5].req_enable_bit,
      o_node_regs[EXT_LO].req_enable_bit}))
    else $error("Fixed node fields wrong");

  disabled_node_a: assert property (i_prog_tos[0][1]
    && !pend[PROG_LO] |=> !pend[PROG_LO])
    else $error("Disabled node received a request");

  exit_gate_a: assert property (i_ce && i_post_valid
    && i_post.kind == POST_EXIT
    && !(i_post.exit_irq_flag && i_post.exit_condition)
    |=> (pend & ~$past(pend)) == '0)
    else $error("Exit posted without flag and condition");

  suspend_slot_a: assert property (i_post_valid && o_post_ready
    && i_post.kind == POST_SUSP
    |=> |(pend[EXT_HI:EXT_LO] & ~$past(pend[EXT_HI:EXT_LO])))
    else $error("Suspension not placed in extended node");

  full_stalls_a: assert property (i_post_valid
    && i_post.kind == POST_ERR && !i_post.bus_err
    && o_cpu_queue_full |-> !o_post_ready)
    else $error("Post taken with full queue");

  special_round_a: assert property (s_round_end ##0 o_self_queue_full
    |=> st.win_src != EXT_SRC || st.fsm != ST_OFFER)
    else $error("External request won with full self queue");

endmodule

/* channel_proc_interrupt_unit_tb.sv */
// Self-checking bench for the co-processor interrupt unit
`timescale 1ns/1ps
module channel_proc_interrupt_unit_tb;
  import coproc_irq_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk = 0, rst_b = 0, pv = 0, xr = 0, busy = 1, take = 0;
  logic cpu_en = 0, pr, sok, xack, kreq, wres, kacc, cack, creq;
  logic cfull, sfull;
  logic [7:0] xp = 0, ep, kprio, cprio;
  logic [4:0] wch;
  logic [3:0] cnode;
  logic [4:0][1:0] ptos;
  arb_ctrl_s actl = '0;
  post_s pst = '0;
  err_status_s est;
  node_s [NODES-1:0] nodes;
  int mismatches = 0, checks_done = 0, xacks = 0, lat[8], n, mx;
  int mp[NODES], mpr[NODES], mr[NODES], mch[NODES];
  int selfq[$] = '{2, 3, 9, 10, 11};
  int extq[$] = '{9, 10, 11};
  int cpuq[$] = '{0, 1};

  channel_proc_interrupt_unit DUT (.i_clk(clk), .i_rst_b(rst_b),
    .i_ce(1'b1), .i_arb_ctrl(actl), .i_prog_tos(ptos),
    .i_error_req_priority(ep), .i_post_valid(pv), .i_post(pst),
    .o_post_ready(pr), .o_suspend_ok(sok), .i_ext_req(xr),
    .i_ext_prio(xp), .o_ext_ack(xack), .i_kernel_busy(busy),
    .i_kernel_accept(kacc), .o_kernel_req(kreq),
    .o_pending_win_priority(kprio), .o_win_resume(wres),
    .o_win_chan(wch), .i_cpu_ack(cack), .o_cpu_req(creq),
    .o_cpu_node(cnode), .o_cpu_prio(cprio), .o_cpu_queue_full(cfull),
    .o_self_queue_full(sfull), .o_err_status(est), .o_node_regs(nodes));
  coproc_kernel_model partner (.i_clk(clk), .i_rst_b(rst_b),
    .i_take_en(take), .i_cpu_en(cpu_en), .i_kernel_req(kreq),
    .i_cpu_req(creq), .o_kernel_accept(kacc), .o_cpu_ack(cack));

  // --------------------------------------------------------------
  // Clock, acknowledge counter and watchdog
  // --------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (xack === 1'b1) xacks++;
  end
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic int lowfree(input int a[$]);
    foreach (a[i]) if (mp[a[i]] == 0) return a[i];
    return -1;
  endfunction
  // Post one request; holds valid until ready is seen at an edge
  task automatic post(input post_kind_e k, input logic f, c,
    input logic [1:0] t, input logic [7:0] p, input logic [4:0] ch,
    input logic be);
    n = 0;
    @(posedge clk);
    #1;
    pst = '{kind: k, exit_irq_flag: f, exit_condition: c,
      service_target_sel: t, req_priority_num: p, chan: ch,
      cause: 4'h3, bus_err: be};
    pv = 1;
    @(negedge clk);
    while (pr !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) mismatches++;
    @(posedge clk);
    #1;
    pv = 0;
  endtask
  task automatic put(input int i, p, r, ch);
    mp[i] = 1;
    mpr[i] = p;
    mr[i] = r;
    mch[i] = ch;
  endtask
  task automatic cmp_nodes;
    for (int i = 0; i < NODES; i++) begin
      chk(nodes[i].req_pending_flag, mp[i]);
      if (mp[i] != 0) begin
        chk(nodes[i].req_priority_num, mpr[i]);
        chk(nodes[i].resume_request_flag, mr[i]);
        if (mr[i] != 0) chk(nodes[i].saved_channel_num, mch[i]);
      end
    end
  endtask
  task automatic waitk(input logic v);
    n = 0;
    while (kreq !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 300) mismatches++;
  endtask
  task automatic end_of_test;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    void'($urandom(33));
    ptos = {5{2'h2 | 2'($urandom_range(0, 1))}};
    ep = 8'($urandom_range(1, 254));
    mp = '{default: 0};
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1;
    for (int i = 0; i < NODES; i++) begin
      chk(nodes[i].req_enable_bit, 1);
      chk(nodes[i].service_target_sel, i < 2 ? 0 : i < 4 ? 1 :
        i < 9 ? ptos[i-4] : 1);
    end
    cmp_nodes();
    chk({kreq, cfull, sfull}, 0);
    $display("reset test done");
    // Exit posts fill the self queue while an external request waits
    xr = 1;
    xp = 8'hff;
    post(POST_EXIT, 0, 1, 1, 8'h11, 0, 0);
    post(POST_EXIT, 1, 0, 1, 8'h12, 0, 0);
    cmp_nodes();
    mx = 0;
    for (int j = 0; j < 5; j++) begin
      n = $urandom_range(1, 254);
      if (n > mx) mx = n;
      put(lowfree(selfq), n, 0, 0);
      post(POST_EXIT, 1, 1, 1, 8'(n), 0, 0);
      cmp_nodes();
      chk(sok, j < 3);
    end
    chk({kreq, kprio, sfull}, {1'b1, 8'hff, 1'b1});
    take = 1;
    repeat (3) @(posedge clk);
    #1;
    chk({kreq, xack}, 2'h2);
    busy = 0;
    waitk(0);
    chk(xack, 1);
    take = 0;
    busy = 1;
    waitk(1);
    chk(kprio, mx);
    xr = 0;
    take = 1;
    busy = 0;
    repeat (200) @(posedge clk);
    #1;
    mp = '{default: 0};
    cmp_nodes();
    chk(xacks, 1);
    $display("self queue test done");
    // Suspension request, accepted with an external request present
    take = 0;
    busy = 1;
    put(9, 8'h40, 1, 5'h15);
    post(POST_SUSP, 0, 0, 1, 8'h40, 5'h15, 0);
    cmp_nodes();
    xr = 1;
    xp = 8'h40;
    waitk(1);
    chk({wres, wch, kprio}, {1'b1, 5'h15, 8'h40});
    take = 1;
    busy = 0;
    waitk(0);
    xr = 0;
    take = 0;
    chk(xack, 0);
    repeat (3) @(posedge clk);
    chk(xacks, 1);
    $display("suspend test done");
    // Error requests into the CPU queue
    post(POST_ERR, 0, 0, 0, 0, 5'h0a, 1);
    mp = '{default: 0};
    cmp_nodes();
    chk(est, {4'h3, 5'h0a});
    for (int j = 0; j < 2; j++) begin
      put(lowfree(cpuq), ep, 0, 0);
      post(POST_ERR, 0, 0, 0, 0, 5'h07, 0);
    end
    cmp_nodes();
    chk({cfull, creq, cnode, cprio}, {2'h3, 4'h0, ep});
    fork
      post(POST_ERR, 0, 0, 0, 0, 5'h09, 0);
      begin
        repeat (4) @(negedge clk);
        chk(pr, 0);
        @(posedge clk);
        #1;
        cpu_en = 1;
      end
    join
    repeat (30) @(posedge clk);
    #1;
    mp = '{default: 0};
    cmp_nodes();
    chk({cfull, est}, {1'b0, 4'h3, 5'h09});
    $display("error test done");
    // Round length for every setting, relative to the shortest
    for (int a = 0; a < 8; a++) begin
      actl = arb_ctrl_s'(3'(a));
      take = 0;
      busy = 1;
      post(POST_EXIT, 1, 1, 1, 8'(a + 1), 0, 0);
      n = 0;
      while (kreq !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      lat[a] = n;
      chk(kprio, a + 1);
      take = 1;
      busy = 0;
      waitk(0);
    end
    for (int a = 0; a < 8; a++) begin
      chk(lat[a] - lat[1], ((a >> 1) + 1) * (a % 2 ? 1 : 2) - 1);
    end
    $display("round length test done");
    end_of_test();
  end
endmodule

/* coproc_irq_pkg.sv */
// Shared constants and types for the co-processor interrupt unit
package coproc_irq_pkg;

  // ----------------------------------------------------------------
  // Sizes and node groups
  // ----------------------------------------------------------------
  localparam int NODES = 12;
  localparam int PRIO_W = 8;
  localparam int CHAN_W = 5;
  localparam int CAUSE_W = 4;
  localparam int IDX_W = 4;
  localparam int CPU_HI = 1;
  localparam int PROG_LO = 4;
  localparam int PROG_HI = 8;
  localparam int EXT_LO = 9;
  localparam int EXT_HI = 11;
  localparam logic [IDX_W-1:0] EXT_SRC = 4'hc;

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [1:0] TOS_CPU = 2'h0;
  localparam logic [1:0] TOS_COP = 2'h1;
  localparam logic REQ_ENABLE = 1'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    POST_EXIT = 2'h0,
    POST_SUSP = 2'h1,
    POST_ERR = 2'h2
  } post_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ARB = 3'h2,
    ST_OFFER = 3'h4
  } arb_state_e;

  // Posting request from the kernel; for a suspension the priority
  // field carries channel_run_priority
  typedef struct packed {
    post_kind_e kind;
    logic exit_irq_flag;
    logic exit_condition;
    logic [1:0] service_target_sel;
    logic [PRIO_W-1:0] req_priority_num;
    logic [CHAN_W-1:0] chan;
    logic [CAUSE_W-1:0] cause;
    logic bus_err;
  } post_s;

  typedef struct packed {
    logic [1:0] arb_cycles_per_round;
    logic arb_cycle_length_sel;
  } arb_ctrl_s;

  typedef struct packed {
    logic req_enable_bit;
    logic [1:0] service_target_sel;
    logic req_pending_flag;
    logic resume_request_flag;
    logic [PRIO_W-1:0] req_priority_num;
    logic [CHAN_W-1:0] saved_channel_num;
  } node_s;

  typedef struct packed {
    logic pending;
    logic resume;
    logic [PRIO_W-1:0] prio;
    logic [CHAN_W-1:0] chan;
  } slot_s;

  typedef struct packed {
    slot_s [NODES-1:0] slot;
    arb_state_e fsm;
    logic [2:0] tick;
    logic [PRIO_W-1:0] win_prio;
    logic [IDX_W-1:0] win_src;
    logic win_resume;
    logic [CHAN_W-1:0] win_chan;
    logic ext_ack;
    logic cpu_req;
    logic [IDX_W-1:0] cpu_node;
    logic [PRIO_W-1:0] cpu_prio;
  } state_s;

  typedef struct packed {
    logic [CAUSE_W-1:0] cause;
    logic [CHAN_W-1:0] chan;
  } err_status_s;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam state_s STATE_RST = '{slot: '0, fsm: ST_IDLE, tick: '0,
    win_prio: '0, win_src: '0, win_resume: 1'b0, win_chan: '0,
    ext_ack: 1'b0, cpu_req: 1'b0, cpu_node: '0, cpu_prio: '0};
  localparam err_status_s ERR_RST = '0;

endpackage

/* coproc_kernel_model.sv */
// Kernel and CPU acknowledge model facing the interrupt unit
`timescale 1ns/1ps
module coproc_kernel_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Willingness set by the bench
  input wire logic i_take_en,
  input wire logic i_cpu_en,
  // Offers from the unit
  input wire logic i_kernel_req,
  input wire logic i_cpu_req,
  // Acceptances back to the unit
  output logic o_kernel_accept,
  output logic o_cpu_ack
);
  logic take_q;
  logic cpu_q;

  // Willingness is read at the edge, before the bench moves it, so the
  // two never race; answers settle just after the edge from the
  // registered offers. Accept is also raised while busy, which the
  // unit must ignore
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_kernel_accept = 1'b0;
      o_cpu_ack = 1'b0;
    end else begin
      take_q = i_take_en;
      cpu_q = i_cpu_en;
      #1;
      o_kernel_accept = take_q & i_kernel_req;
      o_cpu_ack = cpu_q & i_cpu_req;
    end
  end
endmodule

/* err_status_rec.sv */
// Error/debug status capture: cause and executing channel
`timescale 1ns/1ps
module err_status_rec
  import coproc_irq_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Capture strobe and data
  input wire logic i_capture,
  input wire logic [CAUSE_W-1:0] i_cause,
  input wire logic [CHAN_W-1:0] i_chan,
  // Recorded status
  output err_status_s o_status
);

  err_status_s st;
  err_status_s next_st;

  // Every error overwrites the record, bus errors included
  always_comb begin
    next_st = st;
    if (i_capture) begin
      next_st.cause = i_cause;
      next_st.chan = i_chan;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= ERR_RST;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_status = st;

  // Capture lands one cycle after the strobe
  err_capture_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce && i_capture |=> st.cause == $past(i_cause)
      && st.chan == $past(i_chan))
    else $error("Error status not captured");

endmodule
